// ### bfp_cfg.svh
// Purpose: constants of the bridge fault supervisor (offsets, fields, resets, times)
// Assumes: 40 MHz core clock
// Notes: times are in ns; cycle counts are derived in the module
`ifndef BFP_CFG_SVH
`define BFP_CFG_SVH
`define BFP_CLK_PERIOD_NS 25
`define BFP_TPD_FAST_NS 1500
`define BFP_TPD_SLOW_NS 4500
`define BFP_SLEW_STEPS 7
`define BFP_DEAD_NS 500
`define BFP_OCP_QUAL_NS 3000
`define BFP_RETRY_NS 4000000
`define BFP_WAKE_NS 50000
`define BFP_ADDR_CTRL 8'h00
`define BFP_ADDR_CMD 8'h04
`define BFP_ADDR_STATUS 8'h08
`define BFP_CTRL_RESET 8'h00
`define BFP_CMD_CLR_BIT 0
`define BFP_RESP_OKAY 2'h0
`define BFP_RESP_SLVERR 2'h2
`endif

// ### bfp_pkg.sv
// Purpose: types of the bridge fault supervisor
// Assumes: nothing
// Notes: control word occupies byte 0 of the control register
package bfp_pkg;
  typedef enum logic [1:0] {
    BFP_OCP_LATCH = 2'b00,
    BFP_OCP_RETRY = 2'b01,
    BFP_OCP_REPORT = 2'b10,
    BFP_OCP_OFF = 2'b11
  } bfp_ocp_policy_t;
  typedef enum logic [1:0] {
    BFP_MODE_PHEN = 2'b00,
    BFP_MODE_PWM = 2'b01,
    BFP_MODE_INDEP = 2'b10,
    BFP_MODE_RSVD = 2'b11
  } bfp_ctl_mode_t;
  typedef struct packed {
    logic [2:0] slew;
    logic pump_uv_protect_disable;
    bfp_ctl_mode_t mode;
    bfp_ocp_policy_t ocp;
  } bfp_ctrl_t;
  typedef struct packed {
    logic fault_line;
    logic core_ready;
    logic [3:0] fet_oc;
    logic oc;
    logic pump_undervolt_flag;
    logic supply_undervolt_flag;
    logic summary;
  } bfp_status_t;
endpackage

// ### bfp_top.sv
// Purpose: fault supervision, input deglitch and gate sequencing of an H-bridge
// Assumes: comparator and input pins are asynchronous; AXI4-Lite master keeps the protocol
// Notes: half-bridge h follows bridge_inputs[h] directly; oc_detect is {LS2,HS2,LS1,HS1}
// Summary of operation
// - bridge inputs pass a deglitch filter first
// - input-to-output delay 1.5 to 4.5 us by slew
// - turn conducting FET off before opposite on
// - any fault pulls fault indicator low
// - indicator held low until core ready
// - sleep while sleep input low, wake high
// - no serial output data while asleep
// - supply undervolt: outputs off, pump off, flags
// - supply undervolt end resumes, flag stays latched
// - pump undervolt: outputs off, pump on, flags
// - pump undervolt end resumes, flag stays latched
// - disable bit removes pump undervolt protection
// - overcurrent needs qualification time, pump stays on
// - independent mode handles halves separately
// - policy 00 latches off until clear
// - policy 01 retries after retry time
// - policy 10 reports only until clear
// - policy 11 ignores overcurrent entirely
`timescale 1ns/10ps
`include "bfp_cfg.svh"
module bfp_top #(
  parameter int RETRY_CYCLES = (`BFP_RETRY_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] bridge_inputs,
  input wire logic sleep_control_n,
  input wire logic supply_uv_detect,
  input wire logic pump_uv_detect,
  input wire logic [3:0] oc_detect,
  output logic [1:0] hs_gate,
  output logic [1:0] ls_gate,
  output logic fault_indicator_n_o,
  output logic fault_indicator_n_oe,
  output logic pump_enable,
  output logic sdo_enable
);
  import bfp_pkg::*;

  localparam int TPD_FAST_CYC = (`BFP_TPD_FAST_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
  localparam int TPD_SLOW_CYC = (`BFP_TPD_SLOW_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
  localparam int DEAD_CYC = (`BFP_DEAD_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
  localparam int OCP_CYC = (`BFP_OCP_QUAL_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
  localparam int WAKE_CYC = (`BFP_WAKE_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
  localparam int RT_W = 24;

  // linear spread of the delay between fastest and slowest slew setting
  function automatic logic [7:0] tpd_cycles(input logic [2:0] s);
    int t;
    t = TPD_FAST_CYC + (int'(s) * (TPD_SLOW_CYC - TPD_FAST_CYC)) / `BFP_SLEW_STEPS;
    return t[7:0];
  endfunction

  // input synchronisers: {oc[3:0], pump uv, supply uv, sleep, inputs[1:0]}
  logic [8:0] raw;
  logic [8:0] s1_q;
  logic [8:0] s2_q;
  logic [8:0] s3_q;
  logic [8:0] filt_q;
  assign raw = {oc_detect, pump_uv_detect, supply_uv_detect, sleep_control_n, bridge_inputs};

  // sleep bit resets to awake: no false wake edge, and the line goes low at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 9'h004;
      s2_q <= 9'h004;
      s3_q <= 9'h004;
      filt_q <= 9'h004;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end
  end

  logic [1:0] in_f;
  logic slp_n;
  logic suv_raw;
  logic puv_raw;
  logic [3:0] oc_raw;
  assign in_f = filt_q[1:0];
  assign slp_n = filt_q[2];
  assign suv_raw = filt_q[3];
  assign puv_raw = filt_q[4];
  assign oc_raw = filt_q[8:5];

  // register file state
  bfp_ctrl_t ctrl_q;
  logic clr_reg_q;
  bfp_status_t status;
  logic puv_active;
  assign puv_active = puv_raw & ~ctrl_q.pump_uv_protect_disable;

  // sleep and wake
  logic [11:0] wake_cnt_q;
  logic slp_prev_q;
  logic core_ready;
  logic clr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_q <= 12'(WAKE_CYC);
      slp_prev_q <= 1'b1;
    end else begin
      slp_prev_q <= slp_n;
      if (!slp_n) begin
        wake_cnt_q <= 12'(WAKE_CYC);
      end else if (wake_cnt_q != 12'h000) begin
        wake_cnt_q <= wake_cnt_q - 12'h001;
      end
    end
  end
  assign core_ready = slp_n & (wake_cnt_q == 12'h000);
  // a sleep pulse ending counts as a clear command, same as the register bit
  assign clr = clr_reg_q | (slp_n & ~slp_prev_q);

  // overcurrent qualification per transistor
  logic [3:0] oc_qual_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_oc
      logic [7:0] cnt_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= 8'h00;
          oc_qual_q[gi] <= 1'b0;
        end else if (!oc_raw[gi]) begin
          cnt_q <= 8'h00;
          oc_qual_q[gi] <= 1'b0;
        end else if (cnt_q == 8'(OCP_CYC - 1)) begin
          oc_qual_q[gi] <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  endgenerate

  // per half-bridge policy and drive
  logic indep;
  logic [1:0] ev_h;
  logic [1:0] cond_h;
  logic [1:0] shut_q;
  logic [1:0] lvl_q;
  logic fault_act;
  assign indep = (ctrl_q.mode == BFP_MODE_INDEP);
  assign ev_h = {oc_qual_q[3] | oc_qual_q[2], oc_qual_q[1] | oc_qual_q[0]};
  assign cond_h = {oc_raw[3] | oc_raw[2], oc_raw[1] | oc_raw[0]};

  genvar gh;
  generate
    for (gh = 0; gh < 2; gh++) begin : g_half
      logic grp_ev;
      logic grp_cond;
      logic shut_eff;
      logic en;
      logic hs_t;
      logic ls_t;
      logic [RT_W-1:0] rt_q;
      logic [7:0] dg_q;
      logic [7:0] dead_q;
      assign grp_ev = indep ? ev_h[gh] : |ev_h;
      assign grp_cond = indep ? cond_h[gh] : |cond_h;
      assign shut_eff = indep ? shut_q[gh] : |shut_q;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          shut_q[gh] <= 1'b0;
          rt_q <= '0;
        end else begin
          case (ctrl_q.ocp)
            BFP_OCP_LATCH: begin
              if (grp_ev) begin
                shut_q[gh] <= 1'b1;
              end else if (clr && !grp_cond) begin
                shut_q[gh] <= 1'b0;
              end
            end
            BFP_OCP_RETRY: begin
              if (grp_ev && !shut_q[gh]) begin
                shut_q[gh] <= 1'b1;
                rt_q <= RT_W'(RETRY_CYCLES - 1);
              end else if (shut_q[gh]) begin
                if (rt_q != '0) begin
                  rt_q <= rt_q - RT_W'(1);
                end else if (!grp_cond) begin
                  shut_q[gh] <= 1'b0;
                end
              end
            end
            default: begin
              shut_q[gh] <= 1'b0;
            end
          endcase
        end
      end

      // a change must hold for the full delay; shorter pulses restart the count
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dg_q <= 8'h00;
          lvl_q[gh] <= 1'b0;
        end else if (in_f[gh] == lvl_q[gh]) begin
          dg_q <= 8'h00;
        end else if (dg_q + 8'h01 >= tpd_cycles(ctrl_q.slew)) begin
          lvl_q[gh] <= in_f[gh];
          dg_q <= 8'h00;
        end else begin
          dg_q <= dg_q + 8'h01;
        end
      end

      assign en = core_ready & ~suv_raw & ~puv_active & ~shut_eff;
      assign hs_t = en & lvl_q[gh];
      assign ls_t = en & ~lvl_q[gh];

      // off is immediate, on waits for the dead count and the other FET off
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hs_gate[gh] <= 1'b0;
          ls_gate[gh] <= 1'b0;
          dead_q <= 8'h00;
        end else begin
          hs_gate[gh] <= hs_t & (dead_q == 8'h00) & ~ls_gate[gh];
          ls_gate[gh] <= ls_t & (dead_q == 8'h00) & ~hs_gate[gh];
          if ((hs_gate[gh] & ~hs_t) | (ls_gate[gh] & ~ls_t)) begin
            dead_q <= 8'(DEAD_CYC);
          end else if (dead_q != 8'h00) begin
            dead_q <= dead_q - 8'h01;
          end
        end
      end
    end
  endgenerate

  // latched flags; a set in the clear cycle wins
  logic reporting;
  logic [3:0] fet_flag_q;
  logic [3:0] fet_flag_d;
  logic suv_flag_q;
  logic puv_flag_q;
  logic oc_flag_q;
  logic summary_q;
  logic suv_flag_d;
  logic puv_flag_d;
  assign reporting = (ctrl_q.ocp != BFP_OCP_OFF);
  assign fet_flag_d = ({4{reporting}} & oc_qual_q) | (fet_flag_q & ~({4{clr}} & ~oc_raw));
  assign suv_flag_d = suv_raw | (suv_flag_q & ~(clr & ~suv_raw));
  assign puv_flag_d = puv_active | (puv_flag_q & ~(clr & ~puv_raw));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fet_flag_q <= 4'h0;
      suv_flag_q <= 1'b0;
      puv_flag_q <= 1'b0;
      oc_flag_q <= 1'b0;
      summary_q <= 1'b0;
    end else begin
      fet_flag_q <= fet_flag_d;
      suv_flag_q <= suv_flag_d;
      puv_flag_q <= puv_flag_d;
      oc_flag_q <= |fet_flag_d;
      summary_q <= (|fet_flag_d) | suv_flag_d | puv_flag_d;
    end
  end

  // fault line; released while asleep since the core is down
  assign fault_act = slp_n & (~core_ready | suv_raw | puv_active | (|shut_q) |
                     ((ctrl_q.ocp == BFP_OCP_REPORT) & oc_flag_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_indicator_n_o <= 1'b0;
      fault_indicator_n_oe <= 1'b0;
      pump_enable <= 1'b0;
      sdo_enable <= 1'b0;
    end else begin
      fault_indicator_n_o <= 1'b0;
      fault_indicator_n_oe <= fault_act;
      pump_enable <= slp_n & ~suv_raw;
      sdo_enable <= slp_n;
    end
  end

  assign status = '{fault_line: fault_indicator_n_oe, core_ready: core_ready,
                    fet_oc: fet_flag_q, oc: oc_flag_q, pump_undervolt_flag: puv_flag_q,
                    supply_undervolt_flag: suv_flag_q, summary: summary_q};

  // AXI4-Lite write side: address and data taken in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BFP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == `BFP_ADDR_CTRL || awaddr_q == `BFP_ADDR_CMD ||
            awaddr_q == `BFP_ADDR_STATUS) begin
          s_axi_bresp <= `BFP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BFP_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= bfp_ctrl_t'(`BFP_CTRL_RESET);
      clr_reg_q <= 1'b0;
    end else begin
      clr_reg_q <= 1'b0;
      if (do_write && wstrb_q[0]) begin
        if (awaddr_q == `BFP_ADDR_CTRL) begin
          ctrl_q <= bfp_ctrl_t'(wdata_q[7:0]);
        end
        if (awaddr_q == `BFP_ADDR_CMD) begin
          clr_reg_q <= wdata_q[`BFP_CMD_CLR_BIT];
        end
      end
    end
  end

  // AXI4-Lite read side: one outstanding read, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BFP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BFP_RESP_OKAY;
        case (s_axi_araddr)
          `BFP_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_q};
          `BFP_ADDR_CMD: s_axi_rdata <= 32'h0000_0000;
          `BFP_ADDR_STATUS: s_axi_rdata <= {22'h00_0000, status};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BFP_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ### bfp_top_chk.sv
// Purpose: port checker of bfp_top
// Assumes: pins settle within 8 cycles of synchroniser and filter
// Notes: register state is not visible here, so policies are checked in the bench
`timescale 1ns/10ps
module bfp_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] bridge_inputs,
  input wire logic sleep_control_n,
  input wire logic supply_uv_detect,
  input wire logic [1:0] hs_gate,
  input wire logic [1:0] ls_gate,
  input wire logic fault_indicator_n_o,
  input wire logic fault_indicator_n_oe,
  input wire logic pump_enable,
  input wire logic sdo_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  gate_excl_a: assert property ((hs_gate & ls_gate) == 2'b00)
    else $error("both gates of a half on");
  gate_slow_a: assert property ($rose(hs_gate[0]) |-> $past(bridge_inputs[0], 60))
    else $error("gate on before the input settled");
  uv_off_a: assert property ((supply_uv_detect && sleep_control_n)[*8] |->
    fault_indicator_n_oe && !pump_enable && hs_gate == 2'b00 && ls_gate == 2'b00)
    else $error("supply undervolt not acted on");
  sleep_off_a: assert property ((!sleep_control_n)[*8] |-> !sdo_enable && !pump_enable
    && !fault_indicator_n_oe && hs_gate == 2'b00 && ls_gate == 2'b00)
    else $error("sleep state wrong");
  wake_low_a: assert property ($rose(sleep_control_n) ##1 sleep_control_n[*8]
    |-> fault_indicator_n_oe) else $error("line not held low on wake");
  drain_low_a: assert property (fault_indicator_n_o == 1'b0)
    else $error("open drain drives high");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind bfp_top bfp_top_chk i_bfp_top_chk (.*);

// ### bfp_host.sv
// Purpose: host model, AXI4-Lite master that notes expected answers
// Assumes: tasks are entered just after a rising edge
// Notes: address and data are inverted once released, so stale values are not trusted
`timescale 1ns/10ps
module bfp_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [33:0] exp_q[$];
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // faults are cleared through the register, and at the end of the bench once through a sleep pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### bfp_top_bench.sv
// Purpose: self-checking bench of bfp_top
// Assumes: retry shortened to 50 cycles
// Notes: gate checks allow sync, filter and dead time before looking
`timescale 1ns/10ps
`include "bfp_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h expected %0h", $time, g, e); end end
module bfp_top_bench;
  localparam int RETRY = 50;
  localparam logic [1:0] OK = `BFP_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, oc_detect;
  logic [1:0] s_axi_bresp, s_axi_rresp, bridge_inputs, hs_gate, ls_gate;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_control_n;
  logic supply_uv_detect, pump_uv_detect, fault_indicator_n_o, fault_indicator_n_oe;
  logic pump_enable, sdo_enable, fault_line;
  int mismatches, compares, cyc, n, s, seed;
  assign fault_line = fault_indicator_n_oe ? fault_indicator_n_o : 1'b1;
  always #12.5 aclk = ~aclk;
  bfp_top #(.RETRY_CYCLES(RETRY)) i_bfp_top (.*);
  bfp_host i_bfp_host (.*);
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic pins(input logic [1:0] hs, input logic [1:0] ls, input logic ln, input logic pe);
    `CHK({hs_gate, ls_gate, fault_line, pump_enable}, {hs, ls, ln, pe})
  endtask
  task automatic wake();
    for (int i = 0; i < 2200 && fault_line !== 1'b1; i++) tick(1);
    tick(200);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // answers are matched in order against what the host noted
  always @(posedge aclk) begin : mon
    logic [33:0] e;
    if (s_axi_bvalid && s_axi_bready) begin
      e = i_bfp_host.exp_q.pop_front();
      `CHK(s_axi_bresp, e[33:32])
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = i_bfp_host.exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 30000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    {bridge_inputs, supply_uv_detect, pump_uv_detect, oc_detect} = '0;
    sleep_control_n = 1'b1;
    seed = $urandom(32'h0456_4ea2);
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    `CHK(fault_line, 1'b0)
    wake();
    pins(2'b00, 2'b11, 1'b1, 1'b1);
    i_bfp_host.rd(`BFP_ADDR_CTRL, 32'h0000_0000, OK);
    i_bfp_host.rd(8'h0C, 32'h0000_0000, `BFP_RESP_SLVERR);
    i_bfp_host.wr(8'h0C, 32'h0000_00FF, `BFP_RESP_SLVERR);
    i_bfp_host.rd(`BFP_ADDR_CMD, 32'h0000_0000, OK);
    i_bfp_host.wr(`BFP_ADDR_STATUS, 32'h0000_00FF, OK);
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0100, OK);
    n = 5 + $urandom % 40;
    bridge_inputs <= 2'b01;
    tick(n);
    bridge_inputs <= 2'b00;
    tick(100);
    pins(2'b00, 2'b11, 1'b1, 1'b1);
    s = $urandom % 8;
    i_bfp_host.wr(`BFP_ADDR_CTRL, s << 5, OK);
    tick(1);
    bridge_inputs <= 2'b01;
    tick(60 + (s * 120) / 7 - 8);
    pins(2'b00, 2'b11, 1'b1, 1'b1);
    tick(40);
    pins(2'b01, 2'b10, 1'b1, 1'b1);
    supply_uv_detect <= 1'b1;
    tick(10);
    pins(2'b00, 2'b00, 1'b0, 1'b0);
    supply_uv_detect <= 1'b0;
    tick(120);
    pins(2'b01, 2'b10, 1'b1, 1'b1);
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0103, OK);
    i_bfp_host.wr(`BFP_ADDR_CMD, 32'h0000_0001, OK);
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0100, OK);
    pump_uv_detect <= 1'b1;
    tick(10);
    pins(2'b00, 2'b00, 1'b0, 1'b1);
    pump_uv_detect <= 1'b0;
    tick(120);
    pins(2'b01, 2'b10, 1'b1, 1'b1);
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0105, OK);
    i_bfp_host.wr(`BFP_ADDR_CMD, 32'h0000_0001, OK);
    i_bfp_host.wr(`BFP_ADDR_CTRL, 32'h0000_0010, OK);
    pump_uv_detect <= 1'b1;
    tick(10);
    pins(2'b01, 2'b10, 1'b1, 1'b1);
    pump_uv_detect <= 1'b0;
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0100, OK);
    for (int p = 0; p < 4; p++) begin
      i_bfp_host.wr(`BFP_ADDR_CTRL, p, OK);
      oc_detect <= 4'b0001;
      tick(100);
      pins(2'b01, 2'b10, 1'b1, 1'b1);
      tick(40);
      pins(p < 2 ? 2'b00 : 2'b01, p < 2 ? 2'b00 : 2'b10, p == 3, 1'b1);
      oc_detect <= 4'h0;
      tick(90);
      `CHK(fault_line, p[0])
      i_bfp_host.rd(`BFP_ADDR_STATUS, p == 3 ? 32'h0000_0100 :
                    (p[0] ? 32'h0000_0119 : 32'h0000_0319), OK);
      i_bfp_host.wr(`BFP_ADDR_CMD, 32'h0000_0001, OK);
      tick(150);
      pins(2'b01, 2'b10, 1'b1, 1'b1);
    end
    i_bfp_host.wr(`BFP_ADDR_CTRL, 32'h0000_0008, OK);
    oc_detect <= 4'b0001;
    tick(140);
    pins(2'b00, 2'b10, 1'b0, 1'b1);
    oc_detect <= 4'h0;
    i_bfp_host.wr(`BFP_ADDR_CMD, 32'h0000_0001, OK);
    supply_uv_detect <= 1'b1;
    tick(10);
    supply_uv_detect <= 1'b0;
    sleep_control_n <= 1'b0;
    tick(10);
    pins(2'b00, 2'b00, 1'b1, 1'b0);
    `CHK(sdo_enable, 1'b0)
    sleep_control_n <= 1'b1;
    tick(20);
    `CHK(fault_line, 1'b0)
    wake();
    i_bfp_host.rd(`BFP_ADDR_STATUS, 32'h0000_0100, OK);
    `CHK(sdo_enable, 1'b1)
    summarize();
  end
endmodule
